// [include/ifs_pkg.sv]
// ifs_pkg: constants and types shared by the i2c flash front end
// assumes: compiled before every design module that names it
package ifs_pkg;
  localparam logic [3:0]  SLAVE_HI_DEF  = 4'ha;
  localparam int          SECT_WORDS    = 256;
  localparam int          PAGE_N        = 8;
  localparam logic [3:0]  PAGE_N4       = 4'h8;
  localparam logic [3:0]  BYTE_BITS     = 4'h8;
  localparam logic [9:0]  SECT0_BYTE    = 10'h000;
  localparam logic [9:0]  SECT1_BYTE    = 10'h200;
  localparam logic [15:0] ERASED_WORD   = 16'hffff;
  localparam logic [7:0]  FILL_BYTE     = 8'hff;
  localparam logic [2:0]  PIN_RST       = 3'h3;
  localparam int          CLK_NS        = 40;
  localparam int          PROG_TIME_US  = 100;
  localparam int          ERASE_TIME_MS = 500;
  localparam int          PROG_CYCLES   = (PROG_TIME_US * 1000 + CLK_NS - 1) / CLK_NS;
  localparam int          ERASE_CYCLES  = (ERASE_TIME_MS * 1000000 + CLK_NS - 1) / CLK_NS;
  localparam logic [1:0]  CMD_READ      = 2'h0;
  localparam logic [1:0]  CMD_PROG      = 2'h1;
  localparam logic [1:0]  CMD_ERASE     = 2'h2;
  typedef enum logic [1:0] {
    FL_IDLE  = 2'b00,
    FL_PROG  = 2'b01,
    FL_ERASE = 2'b10
  } ifs_fl_st_t;
  typedef enum logic [3:0] {
    B_IDLE     = 4'b0000,
    B_DEV      = 4'b0001,
    B_DEV_ACK  = 4'b0010,
    B_MADR     = 4'b0011,
    B_MADR_ACK = 4'b0100,
    B_WDAT     = 4'b0101,
    B_WDAT_ACK = 4'b0110,
    B_RDAT     = 4'b0111,
    B_RDAT_ACK = 4'b1000
  } ifs_bus_st_t;
endpackage : ifs_pkg

// [src/ifs_flash_core.sv]
// ifs_flash_core: two-sector user_flash_array with timed program and erase
// assumes: requests are levels on clk_i; erase time at least SECT_WORDS cycles
`timescale 1ns/1ns
module ifs_flash_core #(
  parameter int ERASE_CYC = ifs_pkg::ERASE_CYCLES // erase time in cycles
) (
  input  wire logic        clk_i,   // local clock
  input  wire logic        rst_n_i, // synchronised reset, active low
  input  wire logic        prog_i,  // program request level
  input  wire logic        erase_i, // erase request level
  input  wire logic        read_i,  // read strobe
  input  wire logic [8:0]  addr_i,  // word address, msb picks sector
  input  wire logic [15:0] data_i,  // word to program
  output logic      [15:0] rdata_o, // word read
  output logic             busy_o   // program or erase running
);
  logic [15:0]        mem [512];
  ifs_pkg::ifs_fl_st_t st_ff, nxt_st;
  logic               prog_q_ff, erase_q_ff;
  logic [8:0]         addr_ff;
  logic [15:0]        data_ff;
  logic [23:0]        tmr_ff, nxt_tmr;

  wire idle        = st_ff == ifs_pkg::FL_IDLE;
  wire prog_rise   = prog_i & ~prog_q_ff;
  wire erase_rise  = erase_i & ~erase_q_ff;
  wire start_prog  = idle & prog_rise & ~erase_rise;
  wire start_erase = idle & erase_rise & ~prog_rise;
  wire tmr_done    = tmr_ff == 24'h0;
  wire erase_wr    = (st_ff == ifs_pkg::FL_ERASE) & (tmr_ff < 24'(ifs_pkg::SECT_WORDS));
  wire [15:0] old_word = mem[addr_ff];
  assign busy_o = ~idle;

  always_comb begin
    nxt_st  = st_ff;
    nxt_tmr = tmr_done ? tmr_ff : tmr_ff - 24'h1;
    case (st_ff)
      ifs_pkg::FL_IDLE: begin
        if (start_prog) begin
          nxt_st  = ifs_pkg::FL_PROG;
          nxt_tmr = 24'(ifs_pkg::PROG_CYCLES - 1);
        end else if (start_erase) begin
          nxt_st  = ifs_pkg::FL_ERASE;
          nxt_tmr = 24'(ERASE_CYC - 1);
        end
      end
      ifs_pkg::FL_PROG, ifs_pkg::FL_ERASE: begin
        if (tmr_done) nxt_st = ifs_pkg::FL_IDLE;
      end
      default: nxt_st = ifs_pkg::FL_IDLE;
    endcase
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      st_ff      <= ifs_pkg::FL_IDLE;
      tmr_ff     <= 24'h0;
      prog_q_ff  <= 1'b0;
      erase_q_ff <= 1'b0;
      addr_ff    <= 9'h0;
      data_ff    <= 16'h0;
    end else begin
      st_ff      <= nxt_st;
      tmr_ff     <= nxt_tmr;
      prog_q_ff  <= prog_i;
      erase_q_ff <= erase_i;
      if (start_prog | start_erase) addr_ff <= addr_i;
      if (start_prog) data_ff <= data_i;
    end
  end

  // erase walks the sector one word a cycle at the end of the erase time
  always_ff @(posedge clk_i) begin
    if (erase_wr) mem[{addr_ff[8], tmr_ff[7:0]}] <= ifs_pkg::ERASED_WORD;
    else if (st_ff == ifs_pkg::FL_PROG && tmr_done) mem[addr_ff] <= old_word & data_ff;
    if (read_i && idle) rdata_o <= mem[addr_i];
  end

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rst_n_i);
  erase_busy_a: assert property (start_erase |=> busy_o [*8]) else $error("erase busy dropped");
  busy_ignore_a: assert property (busy_o && !tmr_done && (erase_rise || prog_rise) |=> $stable(addr_ff))
    else $error("request taken while busy");
  and_mask_a: assert property (st_ff == ifs_pkg::FL_PROG && tmr_done && !erase_wr
    |=> mem[$past(addr_ff)] == ($past(old_word) & $past(data_ff))) else $error("program not an and");
  erase_fill_a: assert property (erase_wr |=> mem[{$past(addr_ff[8]), $past(tmr_ff[7:0])}] == 16'hffff)
    else $error("erased word not all ones");
  sector_pick_a: assert property (start_erase |=> addr_ff[8] == $past(addr_i[8]))
    else $error("wrong sector latched");
  erase_done_c: cover property (st_ff == ifs_pkg::FL_ERASE && tmr_done);
endmodule : ifs_flash_core

// [src/ifs_i2c_front.sv]
// ifs_i2c_front: i2c slave giving byte access to the user_flash_array
// assumes: link_clk_i much faster than scl; dev_sel_i, mem_size_i, wp_half_i static
// What this block does
// - a rising erase request erases the sector named by the address msb
// - erase uses only the address, never the data word
// - busy stays high from erase start until the sector is fully erased
// - erase or program requests during busy are ignored
// - an erased sector reads back ffff in every word
// - each bit programs once between erases; a word at most twice
// - programming ands the word in; only erase brings ones back
// - bytes of eight bits move both ways at up to 100 kbit/s
// - memory seen by the master is 128, 256, 512 or 1024 bytes
// - sda and scl are only pulled low or released
// - sda changes only while scl is low
// - start is sda falling with scl high; stop is sda rising
// - bus busy from start to stop; repeated start acts like start
// - on acknowledge the sender releases sda, the receiver pulls it low
// - no acknowledge to a new transfer while flash work runs
// - slave address is four fixed bits then three select inputs; 512 and 1024 bytes use the low one or two as address bits
// - address byte lsb: one reads, zero writes
// - write protect blocks writes, whole or upper half; erase is blocked whole, or of the upper half at 1024 bytes only
// - acknowledge the address byte only when it matches
// - flash writes start only after the stop
// - protected target: ack addresses, nack first data byte, no write
// - a rising program request writes the data word at the address
`timescale 1ns/1ns
module ifs_i2c_front #(
  parameter logic [3:0] SLAVE_HI  = ifs_pkg::SLAVE_HI_DEF, // upper slave address bits
  parameter int         ERASE_CYC = ifs_pkg::ERASE_CYCLES  // erase time in ref_clk cycles
) (
  input  wire logic       ref_clk_i,  // 25 MHz local clock
  input  wire logic       reset_n_i,  // async reset, active low
  input  wire logic       link_clk_i, // clock of the bus-facing logic
  input  wire logic       scl_i,      // scl pin level
  output logic            scl_o,      // scl drive value, always low
  output logic            scl_oe_n_o, // scl drive enable, active low
  input  wire logic       sda_i,      // sda pin level
  output logic            sda_o,      // sda drive value, always low
  output logic            sda_oe_n_o, // sda drive enable, active low
  input  wire logic [2:0] dev_sel_i,  // device select address bits
  input  wire logic       wp_i,       // write protect, active high
  input  wire logic       wp_half_i,  // protect only upper half
  input  wire logic [1:0] mem_size_i, // 0:128 1:256 2:512 3:1024 bytes
  output logic            busy_o      // flash program or erase running
);
  // ---- reset release, both domains
  logic [1:0] rr_ff, lr_ff;
  wire rst_n  = rr_ff[1];
  wire lrst_n = lr_ff[1];
  always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) rr_ff <= 2'h0;
    else rr_ff <= {rr_ff[0], 1'b1};
  end
  always_ff @(posedge link_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) lr_ff <= 2'h0;
    else lr_ff <= {lr_ff[0], 1'b1};
  end

  // ---- pin synchronisers: bits {wp, sda, scl}
  logic [2:0] pin_s1_ff, pin_s2_ff, pin_s3_ff, pin_q_ff;
  logic [1:0] pin_p_ff;
  wire [2:0] pin_same = ~(pin_s2_ff ^ pin_s3_ff);
  wire [2:0] nxt_pin_q = (pin_s3_ff & pin_same) | (pin_q_ff & ~pin_same);
  always_ff @(posedge link_clk_i or negedge lrst_n) begin
    if (!lrst_n) begin
      pin_s1_ff <= ifs_pkg::PIN_RST;
      pin_s2_ff <= ifs_pkg::PIN_RST;
      pin_s3_ff <= ifs_pkg::PIN_RST;
      pin_q_ff  <= ifs_pkg::PIN_RST;
      pin_p_ff  <= ifs_pkg::PIN_RST[1:0];
    end else begin
      pin_s1_ff <= {wp_i, sda_i, scl_i};
      pin_s2_ff <= pin_s1_ff;
      pin_s3_ff <= pin_s2_ff;
      pin_q_ff  <= nxt_pin_q;
      pin_p_ff  <= pin_q_ff[1:0];
    end
  end
  wire scl_q     = pin_q_ff[0];
  wire sda_q     = pin_q_ff[1];
  wire wp_q      = pin_q_ff[2];
  wire scl_rise  = scl_q & ~pin_p_ff[0];
  wire scl_fall  = ~scl_q & pin_p_ff[0];
  wire start_det = scl_q & pin_p_ff[0] & pin_p_ff[1] & ~sda_q;
  wire stop_det  = scl_q & pin_p_ff[0] & ~pin_p_ff[1] & sda_q;

  // ---- bus state and decode
  ifs_pkg::ifs_bus_st_t st_ff, nxt_st;
  logic       sda_drv_ff, nxt_drv;
  logic [3:0] bit_cnt_ff;
  logic [7:0] shift_ff, tx_ff;
  logic       mack_ff, rw_ff, rd_pend_ff;
  logic [1:0] hi_ff;
  logic [9:0] addr_ff;
  logic [15:0] rd_word_ff;
  logic [7:0] pg_byte [ifs_pkg::PAGE_N];
  logic [9:0] pg_addr [ifs_pkg::PAGE_N];
  logic [3:0] pg_cnt_ff, cm_idx_ff;
  logic       cm_act_ff, cm_er_ff;
  logic       req_tgl_ff;
  logic [1:0] req_kind_ff;
  logic [9:0] req_addr_ff;
  logic [7:0] req_byte_ff;
  logic [1:0] x_s1_ff, x_s2_ff, x_s3_ff, x_q_ff;

  wire rx_st     = st_ff == ifs_pkg::B_DEV || st_ff == ifs_pkg::B_MADR || st_ff == ifs_pkg::B_WDAT;
  wire byte_done = scl_fall & (bit_cnt_ff == ifs_pkg::BYTE_BITS);
  wire busy_q    = x_q_ff[1];
  wire outst     = req_tgl_ff ^ x_q_ff[0];
  wire link_busy = cm_act_ff | busy_q;
  wire [9:0] addr_mask = {mem_size_i == 2'h3, mem_size_i[1], mem_size_i != 2'h0, 7'h7f};
  wire [9:0] half_bit  = 10'h40 << mem_size_i;
  wire [9:0] addr_inc  = (addr_ff + 10'h1) & addr_mask;
  wire [2:0] sel_mask  = {1'b1, mem_size_i != 2'h3, ~mem_size_i[1]};
  wire sel_hit   = ((shift_ff[3:1] ^ dev_sel_i) & sel_mask) == 3'h0;
  wire dev_hit   = (shift_ff[7:4] == SLAVE_HI) & sel_hit & ~link_busy;
  wire prot      = wp_q & (~wp_half_i | (|(addr_ff & half_bit)));
  wire pg_full   = pg_cnt_ff == ifs_pkg::PAGE_N4;
  wire wr_ok     = ~prot & ~pg_full;
  wire [7:0] rd_byte = addr_ff[0] ? rd_word_ff[7:0] : rd_word_ff[15:8];
  wire tx_load   = scl_fall & ((st_ff == ifs_pkg::B_DEV_ACK & rw_ff) | (st_ff == ifs_pkg::B_RDAT_ACK & mack_ff));
  wire wr_store  = (st_ff == ifs_pkg::B_WDAT) & byte_done & wr_ok;

  always_comb begin
    nxt_st  = st_ff;
    nxt_drv = sda_drv_ff;
    if (stop_det) begin
      nxt_st  = ifs_pkg::B_IDLE;
      nxt_drv = 1'b0;
    end else if (start_det) begin
      nxt_st  = ifs_pkg::B_DEV;   // repeated start handled the same
      nxt_drv = 1'b0;
    end else begin
      case (st_ff)
        ifs_pkg::B_DEV: begin
          if (byte_done) begin
            nxt_st  = dev_hit ? ifs_pkg::B_DEV_ACK : ifs_pkg::B_IDLE;
            nxt_drv = dev_hit;
          end
        end
        ifs_pkg::B_DEV_ACK: begin
          if (scl_fall) begin
            nxt_st  = rw_ff ? ifs_pkg::B_RDAT : ifs_pkg::B_MADR;
            nxt_drv = rw_ff & ~rd_byte[7];
          end
        end
        ifs_pkg::B_MADR: begin
          if (byte_done) begin
            nxt_st  = ifs_pkg::B_MADR_ACK;
            nxt_drv = 1'b1;
          end
        end
        ifs_pkg::B_MADR_ACK, ifs_pkg::B_WDAT_ACK: begin
          if (scl_fall) begin
            nxt_st  = ifs_pkg::B_WDAT;
            nxt_drv = 1'b0;
          end
        end
        ifs_pkg::B_WDAT: begin
          if (byte_done) begin
            nxt_st  = wr_ok ? ifs_pkg::B_WDAT_ACK : ifs_pkg::B_IDLE;
            nxt_drv = wr_ok;
          end
        end
        ifs_pkg::B_RDAT: begin
          if (scl_fall) begin
            nxt_st  = (bit_cnt_ff == ifs_pkg::BYTE_BITS) ? ifs_pkg::B_RDAT_ACK : ifs_pkg::B_RDAT;
            nxt_drv = (bit_cnt_ff != ifs_pkg::BYTE_BITS) & ~tx_ff[6];
          end
        end
        ifs_pkg::B_RDAT_ACK: begin
          if (scl_fall) begin
            nxt_st  = mack_ff ? ifs_pkg::B_RDAT : ifs_pkg::B_IDLE;
            nxt_drv = mack_ff & ~rd_byte[7];
          end
        end
        default: begin
          nxt_st  = ifs_pkg::B_IDLE;
          nxt_drv = 1'b0;
        end
      endcase
    end
  end

  always_ff @(posedge link_clk_i or negedge lrst_n) begin
    if (!lrst_n) begin
      st_ff      <= ifs_pkg::B_IDLE;
      sda_drv_ff <= 1'b0;
    end else begin
      st_ff      <= nxt_st;
      sda_drv_ff <= nxt_drv;
    end
  end

  // ---- bit engine: eight bits then the acknowledge slot
  always_ff @(posedge link_clk_i or negedge lrst_n) begin
    if (!lrst_n) begin
      bit_cnt_ff <= 4'h0;
      shift_ff   <= 8'h0;
      tx_ff      <= 8'h0;
      mack_ff    <= 1'b0;
    end else begin
      if (start_det || stop_det || byte_done) bit_cnt_ff <= 4'h0;
      else if (scl_rise && (rx_st || st_ff == ifs_pkg::B_RDAT)) bit_cnt_ff <= bit_cnt_ff + 4'h1;
      if (scl_rise && rx_st) shift_ff <= {shift_ff[6:0], sda_q};
      if (tx_load) tx_ff <= rd_byte;
      else if (scl_fall && st_ff == ifs_pkg::B_RDAT) tx_ff <= {tx_ff[6:0], 1'b1};
      if (scl_rise && st_ff == ifs_pkg::B_RDAT_ACK) mack_ff <= ~sda_q;
    end
  end

  // ---- address pointer and read prefetch
  wire rd_done = (st_ff == ifs_pkg::B_RDAT) & byte_done;
  wire ma_done = (st_ff == ifs_pkg::B_MADR) & byte_done;
  always_ff @(posedge link_clk_i or negedge lrst_n) begin
    if (!lrst_n) begin
      rw_ff      <= 1'b0;
      hi_ff      <= 2'h0;
      addr_ff    <= 10'h0;
      rd_pend_ff <= 1'b0;
    end else begin
      if (st_ff == ifs_pkg::B_DEV && byte_done) begin
        rw_ff <= shift_ff[0];
        hi_ff <= shift_ff[2:1];
      end
      if (ma_done) addr_ff <= {hi_ff, shift_ff} & addr_mask;
      else if (wr_store || rd_done) addr_ff <= addr_inc;
      if (ma_done || rd_done) rd_pend_ff <= 1'b1;
      else if (~cm_act_ff & ~outst) rd_pend_ff <= 1'b0;
    end
  end

  // ---- page buffer, written to flash after stop
  wire cm_start = stop_det & (pg_cnt_ff != 4'h0) & ~cm_act_ff;
  wire iss_er   = cm_act_ff & cm_er_ff & ~outst;
  wire iss_pg   = cm_act_ff & ~cm_er_ff & (cm_idx_ff != pg_cnt_ff) & ~outst;
  wire cm_done  = cm_act_ff & ~cm_er_ff & (cm_idx_ff == pg_cnt_ff) & ~outst;
  wire iss_rd   = ~cm_act_ff & rd_pend_ff & ~outst;
  wire trig_er  = pg_addr[0] == ifs_pkg::SECT0_BYTE || pg_addr[0] == ifs_pkg::SECT1_BYTE;
  wire [2:0] pg_wi = pg_cnt_ff[2:0];
  wire [2:0] pg_ri = cm_idx_ff[2:0];
  always_ff @(posedge link_clk_i) begin
    if (wr_store) begin
      pg_byte[pg_wi] <= shift_ff;
      pg_addr[pg_wi] <= addr_ff;
    end
  end
  always_ff @(posedge link_clk_i or negedge lrst_n) begin
    if (!lrst_n) begin
      pg_cnt_ff <= 4'h0;
      cm_act_ff <= 1'b0;
      cm_er_ff  <= 1'b0;
      cm_idx_ff <= 4'h0;
    end else begin
      if (cm_done || (st_ff == ifs_pkg::B_WDAT && byte_done && prot)) pg_cnt_ff <= 4'h0;
      else if (wr_store) pg_cnt_ff <= pg_cnt_ff + 4'h1;
      if (cm_start) begin
        cm_act_ff <= 1'b1;
        cm_er_ff  <= trig_er;
        cm_idx_ff <= 4'h0;
      end else begin
        if (cm_done) cm_act_ff <= 1'b0;
        if (iss_er) cm_er_ff <= 1'b0;
        if (iss_pg) cm_idx_ff <= cm_idx_ff + 4'h1;
      end
    end
  end

  // ---- request word held stable until its acknowledge toggles back
  always_ff @(posedge link_clk_i or negedge lrst_n) begin
    if (!lrst_n) begin
      req_tgl_ff  <= 1'b0;
      req_kind_ff <= ifs_pkg::CMD_READ;
      req_addr_ff <= 10'h0;
      req_byte_ff <= 8'h0;
    end else if (iss_er || iss_pg || iss_rd) begin
      req_tgl_ff  <= ~req_tgl_ff;
      req_kind_ff <= iss_er ? ifs_pkg::CMD_ERASE : (iss_pg ? ifs_pkg::CMD_PROG : ifs_pkg::CMD_READ);
      req_addr_ff <= iss_er ? pg_addr[0] : (iss_pg ? pg_addr[pg_ri] : addr_ff);
      req_byte_ff <= pg_byte[pg_ri];
    end
  end

  // ---- acknowledge toggle and busy back into the link domain
  logic [15:0] core_rdata;
  logic        core_busy;
  logic        ack_tgl_ff;
  wire [1:0] x_same = ~(x_s2_ff ^ x_s3_ff);
  wire ack_evt = x_same[0] & (x_s3_ff[0] != x_q_ff[0]);
  always_ff @(posedge link_clk_i or negedge lrst_n) begin
    if (!lrst_n) begin
      x_s1_ff    <= 2'h0;
      x_s2_ff    <= 2'h0;
      x_s3_ff    <= 2'h0;
      x_q_ff     <= 2'h0;
      rd_word_ff <= ifs_pkg::ERASED_WORD;
    end else begin
      x_s1_ff <= {core_busy, ack_tgl_ff};
      x_s2_ff <= x_s1_ff;
      x_s3_ff <= x_s2_ff;
      x_q_ff  <= (x_s3_ff & x_same) | (x_q_ff & ~x_same);
      if (ack_evt && req_kind_ff == ifs_pkg::CMD_READ) rd_word_ff <= core_rdata;
    end
  end

  // ---- flash side on ref_clk_i
  logic [2:0] rq_s_ff, go_ff;
  logic       hold_ff, pend_ff;
  wire rq_evt  = rq_s_ff[2] ^ rq_s_ff[1];
  wire [2:0] go_dec = {req_kind_ff == ifs_pkg::CMD_ERASE, req_kind_ff == ifs_pkg::CMD_PROG,
                       req_kind_ff == ifs_pkg::CMD_READ};
  wire ack_now = pend_ff & ~(|go_ff) & ~hold_ff & ~core_busy;
  wire [15:0] wr_word = req_addr_ff[0] ? {ifs_pkg::FILL_BYTE, req_byte_ff} : {req_byte_ff, ifs_pkg::FILL_BYTE};
  always_ff @(posedge ref_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      rq_s_ff    <= 3'h0;
      go_ff      <= 3'h0;
      hold_ff    <= 1'b0;
      pend_ff    <= 1'b0;
      ack_tgl_ff <= 1'b0;
    end else begin
      rq_s_ff <= {rq_s_ff[1:0], req_tgl_ff};
      go_ff   <= rq_evt ? go_dec : 3'h0;
      hold_ff <= |go_ff;
      if (rq_evt) pend_ff <= 1'b1;
      else if (ack_now) pend_ff <= 1'b0;
      if (ack_now) ack_tgl_ff <= ~ack_tgl_ff;
    end
  end

  ifs_flash_core #(
    .ERASE_CYC (ERASE_CYC)
  ) u_core (
    .clk_i   (ref_clk_i),
    .rst_n_i (rst_n),
    .prog_i  (go_ff[1]),
    .erase_i (go_ff[2]),
    .read_i  (go_ff[0]),
    .addr_i  (req_addr_ff[9:1]),
    .data_i  (wr_word),
    .rdata_o (core_rdata),
    .busy_o  (core_busy)
  );

  assign busy_o     = core_busy;
  assign sda_o      = 1'b0;
  assign sda_oe_n_o = ~sda_drv_ff;
  assign scl_o      = 1'b0;
  assign scl_oe_n_o = 1'b1;         // never stretches or drives scl

  default clocking lcb @(posedge link_clk_i); endclocking
  default disable iff (!lrst_n);
  start_to_dev_a: assert property (start_det && !stop_det |=> st_ff == ifs_pkg::B_DEV && !sda_drv_ff)
    else $error("start not decoded");
  stop_release_a: assert property (stop_det |=> st_ff == ifs_pkg::B_IDLE ##0 !sda_drv_ff)
    else $error("sda held after stop");
  busy_no_ack_a: assert property (st_ff == ifs_pkg::B_DEV && byte_done && link_busy |=> !sda_drv_ff)
    else $error("acked while busy");
  sda_scl_low_a: assert property ($changed(sda_drv_ff) |-> !$past(scl_q) || $past(stop_det) || $past(start_det))
    else $error("sda moved with scl high");
  prot_nack_a: assert property (st_ff == ifs_pkg::B_WDAT && byte_done && prot
    |=> !sda_drv_ff && st_ff == ifs_pkg::B_IDLE && pg_cnt_ff == 4'h0) else $error("protected write acked");
  commit_stop_a: assert property ($rose(cm_act_ff) |-> $past(stop_det))
    else $error("flash write before stop");
  addr_miss_a: assert property (st_ff == ifs_pkg::B_DEV && byte_done && shift_ff[7:4] != SLAVE_HI
    |=> st_ff == ifs_pkg::B_IDLE && !sda_drv_ff) else $error("foreign address acked");
  ack_slot_a: assert property (st_ff == ifs_pkg::B_DEV_ACK && scl_q |-> sda_drv_ff)
    else $error("ack not held low");
  write_commit_c: cover property (cm_done);
  read_byte_c: cover property (st_ff == ifs_pkg::B_RDAT_ACK && scl_rise);
  prot_nack_c: cover property (st_ff == ifs_pkg::B_WDAT && byte_done && prot);
endmodule : ifs_i2c_front

// [verif/ifs_i2c_master.sv]
// ifs_i2c_master: behavioural i2c bus master at 100 kbit/s
// assumes: the bench resolves both wires with pull-ups
`timescale 1ns/1ns
module ifs_i2c_master (
  input  wire logic scl_i,      // resolved scl
  input  wire logic sda_i,      // resolved sda
  output logic      scl_oe_n_o, // low pulls scl
  output logic      sda_oe_n_o  // low pulls sda
);
  localparam int Q = 2500; // quarter bit, 10 us bit
  initial begin
    scl_oe_n_o = 1'b1; // bus idle, both released
    sda_oe_n_o = 1'b1;
  end
  task automatic bit_io(input logic b, output logic s);
    sda_oe_n_o = b; // only while scl low
    #Q scl_oe_n_o = 1'b1;
    #Q s = sda_i;
    #Q scl_oe_n_o = 1'b0;
    #Q;
  endtask : bit_io
  task automatic start_c(); // master alone makes start
    sda_oe_n_o = 1'b1;
    #Q scl_oe_n_o = 1'b1;
    #Q sda_oe_n_o = 1'b0;
    #Q scl_oe_n_o = 1'b0;
    #Q;
  endtask : start_c
  task automatic stop_c();
    sda_oe_n_o = 1'b0;
    #Q scl_oe_n_o = 1'b1;
    #Q sda_oe_n_o = 1'b1;
    #Q;
  endtask : stop_c
  // eight bits then a ninth clock for acknowledge
  task automatic xfer(input logic [7:0] d, input logic ai, output logic [7:0] q, output logic ao);
    for (int i = 7; i >= 0; i--) begin
      bit_io(d[i], q[i]);
    end
    bit_io(ai, ao);
  endtask : xfer
endmodule : ifs_i2c_master

// [verif/test_ifs_i2c_front.sv]
// test_ifs_i2c_front: self-checking bench for the i2c flash front end
// assumes: ifs_pkg compiled first; 1024-byte memory, select bits 100
`timescale 1ns/1ns
module test_ifs_i2c_front;
  logic       ref_clk_i  = 1'b0;
  logic       link_clk_i = 1'b0;
  logic       reset_n_i  = 1'b0;
  logic       wp_i       = 1'b0;
  logic       scl_o, scl_oe_n_o, sda_o, sda_oe_n_o, busy_o, m_scl_n, m_sda_n, a;
  logic [7:0] q;
  int         err_total  = 0;
  int         tests_run  = 0;
  wire        scl = m_scl_n & scl_oe_n_o; // wired and with pull-up
  wire        sda = m_sda_n & sda_oe_n_o;
  always #20 ref_clk_i = ~ref_clk_i;
  always #3 link_clk_i = ~link_clk_i;
  ifs_i2c_front #(.ERASE_CYC(300)) dut_u (.ref_clk_i(ref_clk_i), .reset_n_i(reset_n_i),
    .link_clk_i(link_clk_i), .scl_i(scl), .scl_o(scl_o), .scl_oe_n_o(scl_oe_n_o), .sda_i(sda),
    .sda_o(sda_o), .sda_oe_n_o(sda_oe_n_o), .dev_sel_i(3'h4), .wp_i(wp_i), .wp_half_i(1'b0),
    .mem_size_i(2'h3), .busy_o(busy_o));
  ifs_i2c_master mst_u (.scl_i(scl), .sda_i(sda), .scl_oe_n_o(m_scl_n), .sda_oe_n_o(m_sda_n));
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    tests_run++;
    if (got !== exp) begin
      err_total++;
      $display("unexpected at %0t: got %h exp %h", $time, got, exp);
    end
  endtask : chk
  task automatic wr(input logic [7:0] d, input logic ea);
    mst_u.xfer(d, 1'b1, q, a);
    chk(a, ea);
  endtask : wr
  task automatic rd(input logic nk, input logic [7:0] e);
    mst_u.xfer(8'hff, nk, q, a);
    chk(q, e);
  endtask : rd
  task automatic wseq(input logic [7:0] dv, input logic [7:0] ad);
    mst_u.start_c();
    wr(dv, 1'b0);
    wr(ad, 1'b0);
  endtask : wseq
  task automatic rseq(input logic [7:0] dv, input logic [7:0] ad);
    wseq(dv, ad);
    mst_u.start_c();
    wr(dv | 8'h01, 1'b0);
  endtask : rseq
  task automatic wait_idle();
    int quiet;
    mst_u.stop_c();
    chk(busy_o, 1'b1);
    mst_u.start_c();
    wr(8'ha8, 1'b1);
    mst_u.stop_c();
    // busy dips briefly between erase and each program step
    quiet = 0;
    for (int i = 0; i < 20000 && quiet < 64; i++) begin
      @(posedge ref_clk_i);
      quiet = (busy_o === 1'b0) ? quiet + 1 : 0;
    end
    chk(busy_o | (quiet < 64), 1'b0);
  endtask : wait_idle
  task automatic end_sim();
    $display("%0d checks, %0d mismatches", tests_run, err_total);
    if (err_total == 0 && tests_run > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask : end_sim
  initial begin
    #4000000;
    err_total++;
    end_sim();
  end
  initial begin
    repeat (5) @(posedge ref_clk_i);
    #2 reset_n_i = 1'b1;
    repeat (20) @(posedge ref_clk_i);
    chk({scl_o, sda_o, busy_o, sda_oe_n_o, scl_oe_n_o}, 16'h3);
    wseq(8'ha8, 8'h00); // first byte at 0 erases sector 0
    wr(8'h5a, 1'b0);
    wr(8'hc3, 1'b0);
    wait_idle();
    wseq(8'ha8, 8'h03); // word 1 gets its single program
    wr(8'h0f, 1'b0);
    wait_idle();
    $display("write tests done");
    rseq(8'ha8, 8'h00);
    rd(1'b0, 8'h5a);
    rd(1'b0, 8'hc3);
    rd(1'b0, 8'hff);
    rd(1'b1, 8'h0f);
    mst_u.stop_c();
    mst_u.start_c();
    wr(8'ha0, 1'b1);
    mst_u.start_c();
    wr(8'he8, 1'b1);
    mst_u.stop_c();
    $display("read and address tests done");
    wseq(8'hac, 8'h00); // byte 200 erases sector 1
    wr(8'h12, 1'b0);
    wait_idle();
    rseq(8'hac, 8'h00);
    rd(1'b0, 8'h12);
    rd(1'b1, 8'hff);
    mst_u.stop_c();
    rseq(8'ha8, 8'h00);
    rd(1'b1, 8'h5a);
    mst_u.stop_c();
    @(posedge ref_clk_i);
    #2 wp_i = 1'b1;
    wseq(8'ha8, 8'h01);
    wr(8'h00, 1'b1);
    mst_u.stop_c();
    repeat (50) @(posedge ref_clk_i);
    chk(busy_o, 1'b0);
    $display("sector and protect tests done");
    end_sim();
  end
endmodule : test_ifs_i2c_front
